// file: rtl/chg_pkg.sv
// Purpose: constants and types of the charge sequence controller
// Assumes: 100 MHz system clock
// Notes: times in ms are converted to clock cycles here
package chg_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int LED_STEP_MS = 500;
  localparam int ATTACH_DLY_MS = 500;
  localparam int OPEN_CHK_MS = 70;
  localparam int BLINK_HALF_MS = 500;
  localparam int LED_STEP_CYC = LED_STEP_MS * CYC_PER_MS;
  localparam int ATTACH_DLY_CYC = ATTACH_DLY_MS * CYC_PER_MS;
  localparam int OPEN_CHK_CYC = OPEN_CHK_MS * CYC_PER_MS;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
  // oscillator-period counts, then trickle divider, counter widths and phase count
  localparam int SHORT_OSC = 384;
  localparam int TRICKLE_MIN_OSC = 15;
  localparam int EOC_OSC = 3;
  localparam int SAFETY_OSC = 4_200_000;
  localparam int TRICKLE_DIV = 8;
  localparam int TMR_W = 26;
  localparam int OSC_W = 23;
  localparam int PHASES = 4;
  typedef enum logic [9:0] {
    ST_PWRUP   = 10'h001,
    ST_IDLE    = 10'h002,
    ST_DELAY   = 10'h004,
    ST_OPEN    = 10'h008,
    ST_OFF     = 10'h010,
    ST_SHORT   = 10'h020,
    ST_TRICKLE = 10'h040,
    ST_CHARGE  = 10'h080,
    ST_DONE    = 10'h100,
    ST_FAULT   = 10'h200
  } chg_state_t;
  // comparator and pin levels, all asynchronous to mclk_i
  typedef struct packed {
    logic attach_n;
    logic supply_ok;
    logic temp_ok;
    logic sense_open;
    logic sense_short;
    logic above_min;
    logic above_rech;
    logic below_finish;
    logic osc;
  } chg_cmp_t;
  localparam int CMP_W = $bits(chg_cmp_t);
  localparam logic [CMP_W-1:0] CMP_RST = 9'h100;
endpackage

// file: rtl/chg_sync.sv
// Purpose: two-flop synchroniser for a vector of levels
// Assumes: each bit is an independent slow level
// Notes: reset value is a constant parameter
`timescale 1ns/1ps
module chg_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  if (W < 1) begin : g_bad_width
    $error("chg_sync: W must be positive");
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // chg_sync

// file: rtl/chg_seq.sv
// Purpose: charge sequencer of a single-cell charger
// Assumes: rst_i is the supply power-on reset; comparators are analog levels
// Notes: LED pins are open drain, lit while the enable is high
// Function
// - power-on reset clears the osc, end-of-charge and phase counters, loads both timers, resets the state machine; charging off.
// - at reset the offset switch is on and temperature monitoring runs; reference output is held off until the first clock after reset.
// - charging needs pack attach low plus all other conditions.
// - when detached, LEDs released, offset switch on, temperature monitor running.
// - after reset show red, green, both, each 500 ms, then off.
// - LED outputs are active low sinks, released otherwise.
// - leave idle only with supply above battery and temperature in range.
// - attach falling edge starts 500 ms delay, then 70 ms trickle open check.
// - no battery after 70 ms: output off, LEDs off, wait for toggle.
// - sense must fall below threshold within 70 ms, else latched open fault.
// - sense low means battery connected: red on, start short check.
// - reconnect after verification continues but shows end-of-charge.
// - trickle 384 osc cycles; below 1 V gives latched blinking fault.
// - short fault stays latched until attach toggle or power cycle.
// - trickle at a tenth; after 15 osc cycles above 2.8 V go full.
// - trickle beyond an eighth of safety period gives latched fault.
// - end of charge needs recharge level and low current 3 to 4 cycles.
// - sequencer counts measure internal oscillator periods; the code counts mclk_i cycles for the ms delays, LED steps and blink instead.
// - latched short and trickle-timeout faults blink both LEDs at about 1 Hz.
// - ambient fault lights both LEDs steadily, clears itself.
// - qualified end of charge releases red and lights green.
`timescale 1ns/1ps
module chg_seq
  import chg_pkg::*;
#(
  parameter int LED_STEP = chg_pkg::LED_STEP_CYC,
  parameter int ATTACH_DLY = chg_pkg::ATTACH_DLY_CYC,
  parameter int OPEN_CHK = chg_pkg::OPEN_CHK_CYC,
  parameter int BLINK_HALF = chg_pkg::BLINK_HALF_CYC,
  parameter int SAFETY = chg_pkg::SAFETY_OSC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire chg_pkg::chg_cmp_t cmp_i,
  output logic red_n_o,
  output logic red_oe_o,
  output logic done_led_n_o,
  output logic done_led_oe_o,
  output logic charge_temp_offset_switch_o,
  output logic internal_reference_output_o,
  output logic charger_en_o,
  output logic trickle_o,
  output logic fault_o
);
  localparam int TRICKLE_LIM = SAFETY / TRICKLE_DIV;

  // values the counters cannot hold are refused at elaboration
  if (LED_STEP < 1 || LED_STEP >= 2 ** TMR_W) begin : g_bad_step
    $error("chg_seq: LED_STEP range");
  end
  if (ATTACH_DLY < 1 || ATTACH_DLY >= 2 ** TMR_W) begin : g_bad_delay
    $error("chg_seq: ATTACH_DLY range");
  end
  if (OPEN_CHK < 1 || OPEN_CHK >= 2 ** TMR_W) begin : g_bad_open
    $error("chg_seq: OPEN_CHK range");
  end
  if (BLINK_HALF < 1 || BLINK_HALF >= 2 ** TMR_W) begin : g_bad_blink
    $error("chg_seq: BLINK_HALF range");
  end
  if (TRICKLE_LIM <= TRICKLE_MIN_OSC || SAFETY >= 2 ** OSC_W) begin : g_bad_safety
    $error("chg_seq: SAFETY range");
  end
  if (TRICKLE_MIN_OSC < 1 || TRICKLE_MIN_OSC >= 2 ** OSC_W) begin : g_bad_trickle
    $error("chg_seq: TRICKLE_MIN_OSC range");
  end
  if (SHORT_OSC < 1 || SHORT_OSC >= 2 ** OSC_W) begin : g_bad_short
    $error("chg_seq: SHORT_OSC range");
  end
  if (EOC_OSC < 1 || EOC_OSC > 3) begin : g_bad_eoc
    $error("chg_seq: EOC_OSC must fit the two-bit run counter");
  end
  if (PHASES != 4) begin : g_bad_phases
    $error("chg_seq: the power-up sequence has four phases");
  end

  localparam logic [TMR_W-1:0] STEP_LD = TMR_W'(LED_STEP - 1);
  localparam logic [TMR_W-1:0] DLY_LD = TMR_W'(ATTACH_DLY - 1);
  localparam logic [TMR_W-1:0] OPEN_LD = TMR_W'(OPEN_CHK - 1);
  localparam logic [TMR_W-1:0] BLINK_LD = TMR_W'(BLINK_HALF - 1);
  localparam logic [OSC_W-1:0] SHORT_N = OSC_W'(SHORT_OSC);
  localparam logic [OSC_W-1:0] TRK_MIN_N = OSC_W'(TRICKLE_MIN_OSC);
  localparam logic [OSC_W-1:0] TRK_LIM_N = OSC_W'(TRICKLE_LIM);
  localparam logic [OSC_W-1:0] OSC_MAX = {OSC_W{1'b1}};
  localparam logic [1:0] EOC_N = 2'(EOC_OSC);
  localparam logic [1:0] LAST_PHASE = 2'(PHASES - 1);

  logic [CMP_W-1:0] cmp_q;
  chg_cmp_t cs;
  chg_state_t st_r, st_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic [TMR_W-1:0] blink_cnt_r;
  logic [OSC_W-1:0] osc_cnt_r, osc_cnt_nxt;
  logic [1:0] phase_r;
  logic [1:0] eoc_cnt_r, eoc_cnt_nxt;
  logic blink_r;
  logic osc_d_r;
  logic attach_d_r;
  logic start_pend_r;
  logic gone_r;
  logic show_eoc_r;

  // pins and comparators cross into mclk_i here
  chg_sync #(
    .W(CMP_W),
    .RST_VAL(CMP_RST)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(cmp_i),
    .q_o(cmp_q)
  );

  assign cs = chg_cmp_t'(cmp_q);

  // edge detectors reset to the idle level of their pins, so reset makes no false edge
  wire osc_tick = cs.osc & ~osc_d_r;
  wire att_fall = ~cs.attach_n & attach_d_r;
  // an attach edge is kept while the sequencer cannot take it yet, so a pack
  // present at power-up or plugged in before supply headroom still starts a charge
  wire start_req = att_fall | start_pend_r;
  wire tmr_zero = (tmr_r == '0);
  wire st_chg = (st_nxt != st_r);
  wire in_active = (st_r == ST_SHORT) | (st_r == ST_TRICKLE) | (st_r == ST_CHARGE);
  wire in_drive = in_active | (st_r == ST_OPEN);
  wire temp_flt = in_drive & ~cs.temp_ok;
  wire ready = cs.supply_ok & cs.temp_ok;
  wire eoc_cond = cs.above_rech & cs.below_finish;
  wire blink_wrap = (blink_cnt_r == '0);
  wire leave_idle = (st_r == ST_IDLE) & (st_nxt == ST_DELAY);
  wire start_pend_nxt = ~cs.attach_n & start_req & ~leave_idle;

  // next state; a detached pack overrides everything except the power-up display
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_PWRUP: begin
        if (tmr_zero && phase_r == LAST_PHASE) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // a pack present at power-up counts as a fresh attach
        if (start_req && ready) begin
          st_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (tmr_zero) begin
          st_nxt = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (tmr_zero) begin
          if (cs.sense_open) begin
            st_nxt = ST_OFF;
          end else begin
            st_nxt = ST_SHORT;
          end
        end
      end
      ST_SHORT: begin
        if (osc_cnt_r == SHORT_N) begin
          if (cs.sense_short) begin
            st_nxt = ST_FAULT;
          end else begin
            st_nxt = ST_TRICKLE;
          end
        end
      end
      ST_TRICKLE: begin
        if (osc_cnt_r >= TRK_LIM_N) begin
          st_nxt = ST_FAULT;
        end else if (osc_cnt_r >= TRK_MIN_N && cs.above_min) begin
          st_nxt = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (eoc_cnt_r == EOC_N) begin
          st_nxt = ST_DONE;
        end
      end
      ST_OFF, ST_DONE, ST_FAULT: begin
        st_nxt = st_r;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (st_r != ST_PWRUP && cs.attach_n) begin
      st_nxt = ST_IDLE;
    end
  end

  // shared millisecond timer, loaded on entry to a timed state
  always_comb begin
    if (st_chg) begin
      tmr_nxt = '0;
      if (st_nxt == ST_DELAY) begin
        tmr_nxt = DLY_LD;
      end else if (st_nxt == ST_OPEN) begin
        tmr_nxt = OPEN_LD;
      end
    end else if (st_r == ST_PWRUP && tmr_zero) begin
      tmr_nxt = STEP_LD;
    end else if (!tmr_zero) begin
      tmr_nxt = tmr_r - 1'b1;
    end else begin
      tmr_nxt = tmr_r;
    end
  end

  // oscillator period counter, restarted on every state change
  always_comb begin
    if (st_chg) begin
      osc_cnt_nxt = '0;
    end else if (osc_tick && osc_cnt_r != OSC_MAX) begin
      osc_cnt_nxt = osc_cnt_r + 1'b1;
    end else begin
      osc_cnt_nxt = osc_cnt_r;
    end
  end

  // consecutive low-current samples, one per oscillator period
  always_comb begin
    if (st_r != ST_CHARGE) begin
      eoc_cnt_nxt = '0;
    end else if (!osc_tick) begin
      eoc_cnt_nxt = eoc_cnt_r;
    end else if (!eoc_cond) begin
      eoc_cnt_nxt = '0;
    end else if (eoc_cnt_r != EOC_N) begin
      eoc_cnt_nxt = eoc_cnt_r + 1'b1;
    end else begin
      eoc_cnt_nxt = eoc_cnt_r;
    end
  end

  // LED selection, priority: fault, temperature, progress
  logic red_lit, grn_lit;
  always_comb begin
    red_lit = 1'b0;
    grn_lit = 1'b0;
    case (st_r)
      ST_PWRUP: begin
        red_lit = (phase_r == 2'h0) | (phase_r == 2'h2);
        grn_lit = (phase_r == 2'h1) | (phase_r == 2'h2);
      end
      ST_FAULT: begin
        red_lit = blink_r;
        grn_lit = blink_r;
      end
      ST_SHORT, ST_TRICKLE, ST_CHARGE: begin
        red_lit = ~show_eoc_r;
        grn_lit = show_eoc_r;
      end
      ST_DONE: begin
        grn_lit = 1'b1;
      end
      default: begin
        red_lit = 1'b0;
        grn_lit = 1'b0;
      end
    endcase
    if (temp_flt) begin
      red_lit = 1'b1;
      grn_lit = 1'b1;
    end
  end

  wire chg_on = in_drive & ready;
  wire gone_nxt = in_active & (gone_r | cs.sense_open);
  wire show_nxt = in_active & (show_eoc_r | (gone_r & ~cs.sense_open));

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r <= ST_PWRUP;
      tmr_r <= STEP_LD;
      osc_cnt_r <= '0;
      eoc_cnt_r <= '0;
      phase_r <= '0;
      osc_d_r <= 1'b0;
      attach_d_r <= 1'b1;
      start_pend_r <= 1'b0;
      gone_r <= 1'b0;
      show_eoc_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      osc_cnt_r <= osc_cnt_nxt;
      eoc_cnt_r <= eoc_cnt_nxt;
      osc_d_r <= cs.osc;
      attach_d_r <= cs.attach_n;
      start_pend_r <= start_pend_nxt;
      gone_r <= gone_nxt;
      show_eoc_r <= show_nxt;
      if (st_r == ST_PWRUP && tmr_zero) begin
        phase_r <= phase_r + 1'b1;
      end
    end
  end

  // free-running half-second blink
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      blink_cnt_r <= BLINK_LD;
      blink_r <= 1'b1;
    end else begin
      blink_cnt_r <= blink_wrap ? BLINK_LD : blink_cnt_r - 1'b1;
      blink_r <= blink_wrap ? ~blink_r : blink_r;
    end
  end

  // every pin comes straight from a flip-flop
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      red_n_o <= 1'b1;
      red_oe_o <= 1'b0;
      done_led_n_o <= 1'b1;
      done_led_oe_o <= 1'b0;
      charge_temp_offset_switch_o <= 1'b1;
      internal_reference_output_o <= 1'b0;
      charger_en_o <= 1'b0;
      trickle_o <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      red_n_o <= ~red_lit;
      red_oe_o <= red_lit;
      done_led_n_o <= ~grn_lit;
      done_led_oe_o <= grn_lit;
      charge_temp_offset_switch_o <= ~in_drive;
      internal_reference_output_o <= 1'b1;
      charger_en_o <= chg_on;
      trickle_o <= chg_on & (st_r != ST_CHARGE);
      fault_o <= (st_r == ST_FAULT) | (st_r == ST_OFF);
    end
  end
endmodule // chg_seq

// file: tb/chg_seq_monitor.sv
// Purpose: port-level checks on the charge sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: attached to chg_seq by bind
`timescale 1ns/1ps
module chg_seq_monitor
  import chg_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire chg_pkg::chg_cmp_t cmp_i,
  input wire logic red_n_o,
  input wire logic red_oe_o,
  input wire logic done_led_n_o,
  input wire logic done_led_oe_o,
  input wire logic charge_temp_offset_switch_o,
  input wire logic internal_reference_output_o,
  input wire logic charger_en_o,
  input wire logic trickle_o,
  input wire logic fault_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_reset_values: assert property ($fell(rst_i) |-> !charger_en_o && !fault_o
    && !red_oe_o && !done_led_oe_o && charge_temp_offset_switch_o
    && !internal_reference_output_o) else $error("outputs not at reset values");
  a_ref_up: assert property ($fell(rst_i) |-> ##[1:2] internal_reference_output_o)
    else $error("reference not enabled after reset");
  a_offset_charge: assert property (charger_en_o |-> !charge_temp_offset_switch_o)
    else $error("offset switch on while charging");
  a_leds_sink: assert property ((red_oe_o || done_led_oe_o) |->
    (!red_oe_o || !red_n_o) && (!done_led_oe_o || !done_led_n_o))
    else $error("lit indicator not pulled low");
  a_fault_no_charge: assert property (fault_o |-> !charger_en_o)
    else $error("charger on during latched fault");
  a_detach_off: assert property ($rose(cmp_i.attach_n) |-> ##6 (!charger_en_o && !fault_o))
    else $error("detach did not stop charging");
  a_temp_steady: assert property ((charger_en_o ##1 (!cmp_i.attach_n && !cmp_i.temp_ok) [*6])
    |-> !charger_en_o && (fault_o || red_oe_o && done_led_oe_o))
    else $error("ambient fault not shown");
  a_supply_blocks: assert property (!cmp_i.supply_ok [*6] |-> !charger_en_o)
    else $error("charging without supply headroom");
endmodule // chg_seq_monitor
bind chg_seq chg_seq_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i), .cmp_i(cmp_i),
  .red_n_o(red_n_o), .red_oe_o(red_oe_o), .done_led_n_o(done_led_n_o),
  .done_led_oe_o(done_led_oe_o), .charge_temp_offset_switch_o(charge_temp_offset_switch_o),
  .internal_reference_output_o(internal_reference_output_o), .charger_en_o(charger_en_o),
  .trickle_o(trickle_o), .fault_o(fault_o));

// file: tb/chg_pack_model.sv
// Purpose: battery pack and timing reference seen by the sequencer
// Assumes: comparator levels follow the cell kind at once
// Notes: kind 0 no cell, 1 shorted, 2 dead cell, 3 healthy cell
`timescale 1ns/1ps
module chg_pack_model (
  input wire logic mclk_i,
  input wire logic attached_i,
  input wire logic [1:0] kind_i,
  input wire logic full_i,
  input wire logic loose_i,
  output logic sense_open_o,
  output logic sense_short_o,
  output logic above_min_o,
  output logic above_rech_o,
  output logic below_finish_o,
  output logic osc_o
);
  logic [2:0] div_r = 3'h0;
  logic osc_r = 1'b0;
  // free running, ten clocks a period
  always @(posedge mclk_i) begin
    div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
    if (div_r == 3'h4) osc_r <= ~osc_r;
  end
  assign osc_o = osc_r;
  // an open terminal floats up to the input supply
  assign sense_open_o = !attached_i || kind_i == 2'h0 || loose_i;
  assign sense_short_o = attached_i && kind_i == 2'h1;
  assign above_min_o = attached_i && kind_i == 2'h3;
  assign above_rech_o = above_min_o && full_i;
  assign below_finish_o = above_rech_o;
endmodule // chg_pack_model

// file: tb/charge_sequence_controller_bench.sv
// Purpose: self-checking bench of the charge sequencer
// Assumes: shortened counts, oscillator period of ten clocks
// Notes: every scenario restarts from power-on reset
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module charge_sequence_controller_bench
  import chg_pkg::*;
;
  localparam int LS = 20;
  localparam int AD = 30;
  localparam int OC = 20;
  localparam int BH = 20;
  localparam int SF = 400;
  localparam int SH = 3840;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic attach_n = 1'b1;
  logic supply_ok = 1'b1;
  logic temp_ok = 1'b1;
  logic full = 1'b0;
  logic loose = 1'b0;
  logic [1:0] kind = 2'h3;
  logic s_open, s_short, a_min, a_rech, b_fin, osc, blink;
  logic red_n, red_oe, green_n, green_oe, offs, ref_on, en, trk, flt, red, green;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  chg_cmp_t cmp;
  assign cmp = {attach_n, supply_ok, temp_ok, s_open, s_short, a_min, a_rech, b_fin, osc};
  // released pins are pulled up
  assign red = !(red_oe ? red_n : 1'b1);
  assign green = !(green_oe ? green_n : 1'b1);
  chg_seq #(.LED_STEP(LS), .ATTACH_DLY(AD), .OPEN_CHK(OC), .BLINK_HALF(BH), .SAFETY(SF)) DUT (
    .mclk_i(mclk), .rst_i(rst), .cmp_i(cmp), .red_n_o(red_n), .red_oe_o(red_oe),
    .done_led_n_o(green_n), .done_led_oe_o(green_oe), .charge_temp_offset_switch_o(offs),
    .internal_reference_output_o(ref_on), .charger_en_o(en), .trickle_o(trk), .fault_o(flt));
  chg_pack_model u_pack (.mclk_i(mclk), .attached_i(!attach_n), .kind_i(kind), .full_i(full),
    .loose_i(loose), .sense_open_o(s_open), .sense_short_o(s_short), .above_min_o(a_min),
    .above_rech_o(a_rech), .below_finish_o(b_fin), .osc_o(osc));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      finish_test();
    end
  end
  task finish_test;
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task go(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task boot(input logic [1:0] k);
    kind <= k;
    attach_n <= 1'b1;
    rst <= 1'b1;
    go(8);
    rst <= 1'b0;
    go(LS / 2 + 1);
    for (int i = 0; i < 4; i++) begin
      `CHK("red", 4'h5 >> i & 4'h1, {3'h0, red})
      `CHK("green", 4'h6 >> i & 4'h1, {3'h0, green})
      `CHK("offset", 1'b1, offs)
      go(LS);
    end
    `CHK("ref", 1'b1, ref_on)
  endtask
  task start(input logic [1:0] k);
    boot(k);
    attach_n <= 1'b0;
    go(AD / 2);
    `CHK("en", 1'b0, en)
    go(AD / 2 + 3 + OC / 2);
    `CHK("en", 1'b1, en)
    `CHK("trickle", 1'b1, trk)
    `CHK("offset", 1'b0, offs)
    go(OC / 2 + 4);
  endtask
  task t_charge;
    start(2'h3);
    `CHK("red", 1'b1, red)
    go(SH + 80);
    `CHK("trickle", 1'b1, trk)
    go(180);
    `CHK("trickle", 1'b0, trk)
    `CHK("en", 1'b1, en)
    full <= 1'b1;
    go(15);
    `CHK("green", 1'b0, green)
    go(40);
    `CHK("green", 1'b1, green)
    `CHK("red", 1'b0, red)
    attach_n <= 1'b1;
    full <= 1'b0;
    go(8);
    `CHK("green", 1'b0, green)
  endtask
  task t_short;
    start(2'h1);
    go(SH - 60);
    `CHK("fault", 1'b0, flt)
    go(100);
    `CHK("fault", 1'b1, flt)
    `CHK("yellow", red, green)
    blink = red;
    go(BH);
    `CHK("blink", ~blink, red)
    go(300);
    `CHK("fault", 1'b1, flt)
    attach_n <= 1'b1;
    go(8);
    `CHK("fault", 1'b0, flt)
  endtask
  task t_open;
    start(2'h0);
    `CHK("fault", 1'b1, flt)
    `CHK("en", 1'b0, en)
    `CHK("leds", 2'h0, {red, green})
    go(200);
    `CHK("fault", 1'b1, flt)
  endtask
  task t_temp;
    start(2'h3);
    temp_ok <= 1'b0;
    go(10);
    `CHK("leds", 2'h3, {red, green})
    go(BH + 3);
    `CHK("leds", 2'h3, {red, green})
    temp_ok <= 1'b1;
    go(10);
    `CHK("green", 1'b0, green)
    `CHK("en", 1'b1, en)
  endtask
  task t_supply;
    supply_ok <= 1'b0;
    boot(2'h3);
    attach_n <= 1'b0;
    go(AD + OC + 10);
    `CHK("en", 1'b0, en)
    supply_ok <= 1'b1;
    go(AD + OC / 2 + 8);
    `CHK("en", 1'b1, en)
  endtask
  task t_timeout;
    start(2'h2);
    go(SH + SF * 10 / 8 - 100);
    `CHK("fault", 1'b0, flt)
    go(200);
    `CHK("fault", 1'b1, flt)
  endtask
  task t_loose;
    start(2'h3);
    loose <= 1'b1;
    go(10);
    `CHK("en", 1'b1, en)
    `CHK("red", 1'b1, red)
    loose <= 1'b0;
    go(8);
    `CHK("green", 1'b1, green)
    `CHK("red", 1'b0, red)
    `CHK("en", 1'b1, en)
  endtask
  initial begin
    t_charge;
    t_short;
    t_open;
    t_temp;
    t_supply;
    t_timeout;
    t_loose;
    finish_test();
  end
endmodule // charge_sequence_controller_bench
